// *** rtl/cpm_pkg.sv ***
/*
 * Package of the core performance counter block: register offsets,
 * control field positions, reset values and the carrier structs.
 * Assumes a single core clock and a word-addressed special register port.
 */
package cpm_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] CPM_OFS_CONTROL = 16'hfc00;
    localparam logic [15:0] CPM_OFS_CYCLE = 16'hfc04;
    localparam logic [15:0] CPM_OFS_INSTR = 16'hfc08;
    localparam logic [15:0] CPM_OFS_EVT_ONE = 16'hfc0c;
    localparam logic [15:0] CPM_OFS_EVT_TWO = 16'hfc10;
    localparam logic [15:0] CPM_OFS_EVT_THREE = 16'hfc14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CPM_CTL_MODE_BIT = 0;
    localparam int CPM_CTL_ENABLE_BIT = 1;
    localparam int CPM_CTL_SEL1_LSB = 2;
    localparam int CPM_CTL_SEL2_LSB = 5;
    localparam int CPM_CTL_SEL3_LSB = 8;
    localparam int CPM_CTL_SEL_WIDTH = 3;
    localparam int CPM_CTL_USED_BITS = 11;
    localparam int CPM_WRAP_BIT = 31;
    localparam int CPM_COUNT_WIDTH = 31;
    localparam int CPM_NUM_COUNTERS = 5;
    localparam int CPM_NUM_EVENTS = 8;

    localparam logic [31:0] CPM_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] CPM_TALLY_RESET = 32'h0000_0000;

    typedef enum logic
    {
        CPM_MODE_NORMAL,
        CPM_MODE_TASK
    } cpm_mode_t;

    // Special register access request from the core
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } cpm_sfr_req_t;

    // Per-cycle event feed from pipeline, caches and debug logic
    typedef struct packed
    {
        logic retire;
        logic [CPM_NUM_EVENTS-1:0] evt1;
        logic [CPM_NUM_EVENTS-1:0] evt2;
        logic [CPM_NUM_EVENTS-1:0] evt3;
        logic dbg_start;
        logic dbg_stop;
    } cpm_feed_t;

endpackage : cpm_pkg

// *** rtl/cpm_tally.sv ***
/*
 * One 31-bit tally with a sticky wrap flag in bit 31.
 * Assumes the caller gates inc_in with the counting condition and only
 * raises wr_in while counting is off.
 */
`timescale 1ns/100ps
`default_nettype none

module cpm_tally
    import cpm_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire logic inc_in,
    input wire logic wr_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] value_out
);

    logic [CPM_COUNT_WIDTH-1:0] count_q;
    logic [CPM_COUNT_WIDTH-1:0] count_d;
    logic wrap_q;
    logic wrap_d;
    wire logic at_max;

    // Plain rollover to zero, carry becomes the sticky flag
    assign at_max = &count_q;

    always_comb
    begin
        count_d = count_q;
        wrap_d = wrap_q;
        if (wr_in)
        begin
            count_d = wdata_in[CPM_COUNT_WIDTH-1:0];
            wrap_d = wdata_in[CPM_WRAP_BIT];
        end
        else if (inc_in)
        begin
            count_d = count_q + 31'h1;
            // Only a software write or reset ever lowers the flag
            wrap_d = wrap_q | at_max;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count_q <= CPM_TALLY_RESET[CPM_COUNT_WIDTH-1:0];
            wrap_q <= CPM_TALLY_RESET[CPM_WRAP_BIT];
        end
        else
        begin
            count_q <= count_d;
            wrap_q <= wrap_d;
        end
    end

    assign value_out = {wrap_q, count_q};

endmodule // cpm_tally

`default_nettype wire

// *** rtl/cpm_counters.sv ***
/*
 * Core performance counter unit: control register, cycle, retired
 * instruction and three selectable event tallies on the core special
 * register port.
 * Assumes feed signals and register requests come from logic on clock_in;
 * only rst_b_in is asynchronous and is released through two flip-flops.
 */
// Overview of operation
// - Counting never stalls or alters the processor.
// - Enable bit stops or runs all five.
// - Mode bit 0: normal 0, task 1.
// - One mode bit governs every counter.
// - Normal mode counts whenever enabled.
// - Task mode counts from the debug start cycle.
// - Counting needs enable plus normal mode or an active task window.
// - Tally writes while counting discarded, else stored; control writes always stored.
// - Counters readable at any time.
// - 31-bit counters rolling over to zero.
// - Bit 31 sticky wrap flag.
// - Retired instructions counted from start cycle.
// - Cache misses counted from start cycle.
// - Three 3-bit event select fields.
// - Control bits 31:11 reserved, read zero.
// - Decode control at fc00, tallies to fc14.
// - Cycle per clock, instruction per retire.
// - Only software or reset clears a wrap flag.
`timescale 1ns/100ps
`default_nettype none

module cpm_counters
    import cpm_pkg::*;
#(
    parameter int EVENT_LINES = CPM_NUM_EVENTS
)
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire cpm_sfr_req_t sfr_req_in,
    input wire cpm_feed_t feed_in,
    output logic [31:0] sfr_rdata_out,
    output logic sfr_hit_out,
    output logic counting_out
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (EVENT_LINES != (1 << CPM_CTL_SEL_WIDTH))
    begin : g_bad_events
        $error("EVENT_LINES must match the 3-bit event select width");
    end

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    wire logic rst_b;
    assign rst_b = rst_sync_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic sel_ctl;
    wire logic sel_cyc;
    wire logic sel_ins;
    wire logic sel_ev1;
    wire logic sel_ev2;
    wire logic sel_ev3;
    wire logic any_sel;

    assign sel_ctl = sfr_req_in.addr == CPM_OFS_CONTROL;
    assign sel_cyc = sfr_req_in.addr == CPM_OFS_CYCLE;
    assign sel_ins = sfr_req_in.addr == CPM_OFS_INSTR;
    assign sel_ev1 = sfr_req_in.addr == CPM_OFS_EVT_ONE;
    assign sel_ev2 = sfr_req_in.addr == CPM_OFS_EVT_TWO;
    assign sel_ev3 = sfr_req_in.addr == CPM_OFS_EVT_THREE;
    assign any_sel = sel_ctl | sel_cyc | sel_ins | sel_ev1 | sel_ev2 | sel_ev3;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic enable_q;
    cpm_mode_t gating_mode_select_q;
    logic [CPM_CTL_SEL_WIDTH-1:0] event_select_one_q;
    logic [CPM_CTL_SEL_WIDTH-1:0] event_select_two_q;
    logic [CPM_CTL_SEL_WIDTH-1:0] event_select_three_q;
    wire logic ctl_wr;
    wire logic [31:0] ctl_value;

    assign ctl_wr = sfr_req_in.wr & sel_ctl;

    always_ff @(posedge clock_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enable_q <= CPM_CONTROL_RESET[CPM_CTL_ENABLE_BIT];
            gating_mode_select_q <= CPM_MODE_NORMAL;
            event_select_one_q <= CPM_CONTROL_RESET[CPM_CTL_SEL1_LSB +: CPM_CTL_SEL_WIDTH];
            event_select_two_q <= CPM_CONTROL_RESET[CPM_CTL_SEL2_LSB +: CPM_CTL_SEL_WIDTH];
            event_select_three_q <= CPM_CONTROL_RESET[CPM_CTL_SEL3_LSB +: CPM_CTL_SEL_WIDTH];
        end
        else if (ctl_wr)
        begin
            enable_q <= sfr_req_in.wdata[CPM_CTL_ENABLE_BIT];
            gating_mode_select_q <= cpm_mode_t'(sfr_req_in.wdata[CPM_CTL_MODE_BIT]);
            event_select_one_q <= sfr_req_in.wdata[CPM_CTL_SEL1_LSB +: CPM_CTL_SEL_WIDTH];
            event_select_two_q <= sfr_req_in.wdata[CPM_CTL_SEL2_LSB +: CPM_CTL_SEL_WIDTH];
            event_select_three_q <= sfr_req_in.wdata[CPM_CTL_SEL3_LSB +: CPM_CTL_SEL_WIDTH];
        end
    end

    // Reserved upper bits always read as zero
    assign ctl_value = {{(32 - CPM_CTL_USED_BITS){1'b0}},
                        event_select_three_q,
                        event_select_two_q,
                        event_select_one_q,
                        enable_q,
                        gating_mode_select_q};

    // ------------------------------------------------------------
    // Task window
    // ------------------------------------------------------------
    // Start wins over a stop seen in the same cycle, so no start is lost
    logic window_q;

    always_ff @(posedge clock_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            window_q <= 1'b0;
        end
        else if (feed_in.dbg_start)
        begin
            window_q <= 1'b1;
        end
        else if (feed_in.dbg_stop)
        begin
            window_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Counting condition
    // ------------------------------------------------------------
    // Start pulse counts in its own cycle, not one late
    wire logic mode_active;
    wire logic counting;

    assign mode_active = (gating_mode_select_q == CPM_MODE_NORMAL)
                       | window_q | feed_in.dbg_start;
    assign counting = enable_q & mode_active;

    // ------------------------------------------------------------
    // Increment selection
    // ------------------------------------------------------------
    // Event streams are only observed; nothing here feeds back to the core
    wire logic [CPM_NUM_COUNTERS-1:0] inc;
    wire logic [CPM_NUM_COUNTERS-1:0] wr;
    wire logic [CPM_NUM_COUNTERS-1:0] sel_cnt;

    assign inc[0] = counting;
    assign inc[1] = counting & feed_in.retire;
    assign inc[2] = counting & feed_in.evt1[event_select_one_q];
    assign inc[3] = counting & feed_in.evt2[event_select_two_q];
    assign inc[4] = counting & feed_in.evt3[event_select_three_q];

    assign sel_cnt = {sel_ev3, sel_ev2, sel_ev1, sel_ins, sel_cyc};

    // Writes are dropped while counting so a tally never jumps mid-measure
    assign wr = {CPM_NUM_COUNTERS{sfr_req_in.wr & ~counting}} & sel_cnt;

    // ------------------------------------------------------------
    // Tallies
    // ------------------------------------------------------------
    logic [31:0] tally_value [CPM_NUM_COUNTERS];

    for (genvar i = 0; i < CPM_NUM_COUNTERS; i++)
    begin : g_tally
        cpm_tally u_tally
        (
            .clock_in(clock_in),
            .rst_b_in(rst_b),
            .inc_in(inc[i]),
            .wr_in(wr[i]),
            .wdata_in(sfr_req_in.wdata),
            .value_out(tally_value[i])
        );
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [31:0] rd_mux;

    assign rd_mux = sel_ctl ? ctl_value :
                    sel_cyc ? tally_value[0] :
                    sel_ins ? tally_value[1] :
                    sel_ev1 ? tally_value[2] :
                    sel_ev2 ? tally_value[3] :
                    sel_ev3 ? tally_value[4] :
                    32'h0000_0000;

    logic [31:0] rdata_q;
    logic hit_q;

    always_ff @(posedge clock_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata_q <= 32'h0000_0000;
            hit_q <= 1'b0;
        end
        else
        begin
            rdata_q <= sfr_req_in.rd ? rd_mux : 32'h0000_0000;
            hit_q <= (sfr_req_in.rd | sfr_req_in.wr) & any_sel;
        end
    end

    assign sfr_rdata_out = rdata_q;
    assign sfr_hit_out = hit_q;
    assign counting_out = counting;

endmodule // cpm_counters

`default_nettype wire

// *** verif/cpm_counters_props.sv ***
/* Port checker for cpm_counters.
   Assumes it is bound to every cpm_counters instance. */
`timescale 1ns/100ps
`default_nettype none
module cpm_counters_props
    import cpm_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_b_in,
    input wire cpm_sfr_req_t sfr_req_in,
    input wire cpm_feed_t feed_in,
    input wire logic [31:0] sfr_rdata_out,
    input wire logic sfr_hit_out,
    input wire logic counting_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    wire logic acc = sfr_req_in.rd | sfr_req_in.wr;
    wire logic map_ok = sfr_req_in.addr inside {CPM_OFS_CONTROL, CPM_OFS_CYCLE,
        CPM_OFS_INSTR, CPM_OFS_EVT_ONE, CPM_OFS_EVT_TWO, CPM_OFS_EVT_THREE};
    wire logic ctl_wr = sfr_req_in.wr && sfr_req_in.addr == CPM_OFS_CONTROL;
    wire logic cyc_rd = sfr_req_in.rd && !sfr_req_in.wr && sfr_req_in.addr == CPM_OFS_CYCLE;
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_hit_mapped: assert property (acc && map_ok |=> sfr_hit_out)
        else $error("mapped access without hit");
    a_miss_zero: assert property (acc && !map_ok |=> !sfr_hit_out && sfr_rdata_out == 32'h0)
        else $error("unmapped access answered");
    a_idle_quiet: assert property (!sfr_req_in.rd |=> sfr_rdata_out == 32'h0)
        else $error("read data without read");
    a_ctl_reserved: assert property (sfr_req_in.rd && sfr_req_in.addr == CPM_OFS_CONTROL
        |=> sfr_rdata_out[31:11] == 21'h0)
        else $error("control reserved bits not zero");
    a_disable_halts: assert property (ctl_wr && !sfr_req_in.wdata[1] |=> !counting_out)
        else $error("counting after disable");
    a_normal_runs: assert property (ctl_wr && sfr_req_in.wdata[1:0] == 2'b10 |=> counting_out)
        else $error("normal mode not counting");
    a_rise_cause: assert property ($rose(counting_out) |-> feed_in.dbg_start || $past(ctl_wr))
        else $error("counting started without cause");
    a_fall_cause: assert property ($fell(counting_out) |-> $past(feed_in.dbg_stop) || $past(ctl_wr))
        else $error("counting stopped without cause");
    a_cycle_step: assert property ((cyc_rd && counting_out) ##1 cyc_rd
        |=> sfr_rdata_out[30:0] == 31'($past(sfr_rdata_out[30:0]) + 31'h1))
        else $error("cycle tally did not step by one");
    c_task_start: cover property (feed_in.dbg_start && counting_out);
    c_unmapped: cover property (acc && !map_ok);
    c_wrap_seen: cover property (sfr_hit_out && sfr_rdata_out[31]);
endmodule // cpm_counters_props
bind cpm_counters cpm_counters_props u_props (.clock_in, .rst_b_in, .sfr_req_in, .feed_in,
    .sfr_rdata_out, .sfr_hit_out, .counting_out);
`default_nettype wire

// *** verif/cpm_feed_model.sv ***
/* Pipeline, cache and debug event feed for cpm_counters.
   Assumes its inputs are driven on the falling clock edge. */
`timescale 1ns/100ps
`default_nettype none
module cpm_feed_model
    import cpm_pkg::*;
(
    input wire logic retire_in,
    input wire logic [2:0] pick_in,
    input wire logic start_in,
    input wire logic stop_in,
    output var cpm_feed_t feed_out
);
    // One event line per bank, so a wrong select counts nothing
    wire logic [CPM_NUM_EVENTS-1:0] hot = 8'h1 << pick_in;
    assign feed_out = '{retire: retire_in, evt1: hot, evt2: hot, evt3: hot,
        dbg_start: start_in, dbg_stop: stop_in};
endmodule // cpm_feed_model
`default_nettype wire

// *** verif/cpm_counters_tb.sv ***
/* Self-checking bench for cpm_counters.
   Assumes cpm_feed_model and the bound checker are compiled. */
`timescale 1ns/100ps
`default_nettype none
module cpm_counters_tb
    import cpm_pkg::*;
;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    cpm_sfr_req_t req = '0;
    cpm_feed_t feed;
    logic [31:0] rdata;
    logic hit;
    logic counting;
    logic st = 1'b0;
    logic sp = 1'b0;
    logic [2:0] pick = 3'h0;
    logic ret = 1'b1;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    always #2 clock_in = ~clock_in;
    cpm_feed_model u_feed (.retire_in(ret), .pick_in(pick), .start_in(st), .stop_in(sp), .feed_out(feed));
    cpm_counters u_dut (.clock_in, .rst_b_in, .sfr_req_in(req), .feed_in(feed),
        .sfr_rdata_out(rdata), .sfr_hit_out(hit), .counting_out(counting));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(negedge clock_in);
        req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clock_in);
        req = '0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic h);
        acc(1'b0, a, 32'h0);
        chk(rdata, exp);
        chk({31'h0, hit}, {31'h0, h});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < 6; i++)
            rdc(16'hfc00 + 16'(4 * i), 32'h0, 1'b1);
        rdc(16'hfc18, 32'h0, 1'b0);
    endtask
    task automatic t_rw;
        for (int i = 1; i < 6; i++)
            acc(1'b1, 16'hfc00 + 16'(4 * i), 32'h8123_4560 + 32'(i));
        for (int i = 1; i < 6; i++)
            rdc(16'hfc00 + 16'(4 * i), 32'h8123_4560 + 32'(i), 1'b1);
        acc(1'b1, CPM_OFS_CONTROL, 32'hffff_fffc);
        rdc(CPM_OFS_CONTROL, 32'h0000_07fc, 1'b1);
    endtask
    task automatic t_norm;
        for (int p = 0; p < 8; p++)
        begin
            pick = 3'(p);
            // Even passes retire nothing, odd passes retire every cycle
            ret = pick[0];
            for (int i = 1; i < 6; i++)
                acc(1'b1, 16'hfc00 + 16'(4 * i), 32'h0);
            acc(1'b1, CPM_OFS_CONTROL, {21'h0, 3'(pick + 3'h1), (pick[0] ? pick : ~pick), pick, 2'b10});
            // Dropped write, then two back-to-back cycle reads
            acc(1'b1, CPM_OFS_CYCLE, 32'h55);
            chk({31'h0, counting}, 32'h1);
            @(negedge clock_in);
            req = '{wr: 1'b0, rd: 1'b1, addr: CPM_OFS_CYCLE, wdata: 32'h0};
            repeat (2) @(negedge clock_in);
            chk(rdata, 32'h4);
            req = '0;
            repeat (3) @(negedge clock_in);
            acc(1'b1, CPM_OFS_CONTROL, 32'h0);
            rdc(CPM_OFS_CYCLE, 32'ha, 1'b1);
            rdc(CPM_OFS_INSTR, pick[0] ? 32'ha : 32'h0, 1'b1);
            rdc(CPM_OFS_EVT_ONE, 32'ha, 1'b1);
            rdc(CPM_OFS_EVT_TWO, pick[0] ? 32'ha : 32'h0, 1'b1);
            rdc(CPM_OFS_EVT_THREE, 32'h0, 1'b1);
        end
        ret = 1'b1;
    endtask
    task automatic t_task(input int m);
        acc(1'b1, CPM_OFS_CYCLE, 32'h0);
        acc(1'b1, CPM_OFS_INSTR, 32'h0);
        acc(1'b1, CPM_OFS_CONTROL, 32'h3);
        repeat (2) @(negedge clock_in);
        chk({31'h0, counting}, 32'h0);
        st = 1'b1;
        @(negedge clock_in);
        st = 1'b0;
        chk({31'h0, counting}, 32'h1);
        repeat (m - 1) @(negedge clock_in);
        sp = 1'b1;
        @(negedge clock_in);
        sp = 1'b0;
        chk({31'h0, counting}, 32'h0);
        acc(1'b1, CPM_OFS_CONTROL, 32'h0);
        rdc(CPM_OFS_CYCLE, 32'(m + 1), 1'b1);
        rdc(CPM_OFS_INSTR, 32'(m + 1), 1'b1);
    endtask
    task automatic t_wrap;
        acc(1'b1, CPM_OFS_CYCLE, 32'h7fff_fffe);
        acc(1'b1, CPM_OFS_CONTROL, 32'h2);
        @(negedge clock_in);
        acc(1'b1, CPM_OFS_CONTROL, 32'h0);
        rdc(CPM_OFS_CYCLE, 32'h8000_0001, 1'b1);
        repeat (5) @(negedge clock_in);
        rdc(CPM_OFS_CYCLE, 32'h8000_0001, 1'b1);
        acc(1'b1, CPM_OFS_CYCLE, 32'h0);
        rdc(CPM_OFS_CYCLE, 32'h0, 1'b1);
    endtask
    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clock_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            end_sim();
        end
    end
    initial
    begin
        repeat (2) @(negedge clock_in);
        rst_b_in = 1'b1;
        repeat (3) @(negedge clock_in);
        t_reset();
        t_rw();
        t_norm();
        t_task(6);
        t_wrap();
        end_sim();
    end
endmodule // cpm_counters_tb
`default_nettype wire
